/* File: rtl/odv_consts.vh */
// odv_consts.vh: register offsets, field positions and reset values
// assumes inclusion by the output driver level bank only
`ifndef ODV_CONSTS_VH
`define ODV_CONSTS_VH
`define ODV_ADDR_W 8
`define ODV_DATA_W 16
`define ODV_OFF_L1 8'h68
`define ODV_OFF_R1 8'h69
`define ODV_OFF_L2 8'h6A
`define ODV_OFF_R2 8'h6B
`define ODV_BIT_ON 15
`define ODV_BIT_SIL 14
`define ODV_BIT_ZC 13
`define ODV_BIT_INV 10
`define ODV_BIT_ROUTE 9
`define ODV_BIT_COMMIT 8
`define ODV_LVL_HI 7
`define ODV_LVL_LO 2
`define ODV_LVL_RST 6'h39
`define ODV_ROUTE_RST 1'h1
`endif

/* File: rtl/odv_output_driver_volume_regs.v */
// odv_output_driver_volume_regs: four output driver level registers
// assumes a plain strobe register port and a zero-cross pulse per driver
// Function
// - first pair level codes stay pending until a 1 hits bit 8 of either.
// - second pair level codes stay pending until a 1 hits bit 8 of either.
// - with zero-cross bit 13 set a gain change waits for a zero crossing.
// - second right register bit 10 enables the inverting amp, reset 0.
// - second right bit 9 routes the amp to the driver at 1, reset 1.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "odv_consts.vh"
module odv_output_driver_volume_regs (
  // clock, reset, enable
  input wire mclk,
  input wire rst_n,
  input wire clk_en,
  // register port
  input wire [`ODV_ADDR_W-1:0] reg_addr,
  input wire [`ODV_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`ODV_DATA_W-1:0] reg_rdata,
  // zero-cross pulses from the analogue side, order l1 r1 l2 r2
  input wire [3:0] zero_seen,
  // driver controls, order l1 r1 l2 r2
  output reg [3:0] driver_on,
  output reg [3:0] driver_silence,
  output reg [23:0] level_applied,
  output reg inverting_amp_on,
  output reg amp_output_route
);
  reg [3:0] zc_en;
  reg [23:0] level_pend;
  reg [23:0] level_target;
  reg [3:0] zc_wait;
  reg [3:0] zs_a;
  reg [3:0] zs_b;
  reg [3:0] zs_c;
  wire [3:0] hit;
  wire commit1;
  wire commit2;
  wire [3:0] zcross;

  assign hit[0] = reg_wr && reg_addr == `ODV_OFF_L1;
  assign hit[1] = reg_wr && reg_addr == `ODV_OFF_R1;
  assign hit[2] = reg_wr && reg_addr == `ODV_OFF_L2;
  assign hit[3] = reg_wr && reg_addr == `ODV_OFF_R2;
  assign commit1 = (hit[0] | hit[1]) & reg_wdata[`ODV_BIT_COMMIT];
  assign commit2 = (hit[2] | hit[3]) & reg_wdata[`ODV_BIT_COMMIT];
  // zero crossings come from another domain: agreement of stages 2 and 3
  assign zcross = zs_b & zs_c;

  always @(posedge mclk) begin
    if (!rst_n) begin
      zs_a <= 4'h0;
      zs_b <= 4'h0;
      zs_c <= 4'h0;
    end else if (clk_en) begin
      zs_a <= zero_seen;
      zs_b <= zs_a;
      zs_c <= zs_b;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_drv
      wire commit_i = (i < 2) ? commit1 : commit2;
      wire [5:0] wlvl = reg_wdata[`ODV_LVL_HI:`ODV_LVL_LO];
      // the commit applies the value written in the same cycle too
      wire [5:0] new_lvl = hit[i] ? wlvl : level_pend[i*6 +: 6];
      always @(posedge mclk) begin
        if (!rst_n) begin
          driver_on[i] <= 1'h0;
          driver_silence[i] <= 1'h0;
          zc_en[i] <= 1'h0;
          level_pend[i*6 +: 6] <= `ODV_LVL_RST;
          level_target[i*6 +: 6] <= `ODV_LVL_RST;
          level_applied[i*6 +: 6] <= `ODV_LVL_RST;
          zc_wait[i] <= 1'h0;
        end else if (clk_en) begin
          if (hit[i]) begin
            driver_on[i] <= reg_wdata[`ODV_BIT_ON];
            driver_silence[i] <= reg_wdata[`ODV_BIT_SIL];
            zc_en[i] <= reg_wdata[`ODV_BIT_ZC];
            level_pend[i*6 +: 6] <= wlvl;
          end
          if (commit_i) begin
            // a zero crossing sampled with the commit does not count
            if (hit[i] ? reg_wdata[`ODV_BIT_ZC] : zc_en[i]) begin
              level_target[i*6 +: 6] <= new_lvl;
              zc_wait[i] <= 1'h1;
            end else begin
              level_applied[i*6 +: 6] <= new_lvl;
              zc_wait[i] <= 1'h0;
            end
          end else if (zc_wait[i] && (zcross[i] || !zc_en[i])) begin
            // clearing zero-cross while waiting releases the gain at once
            level_applied[i*6 +: 6] <= level_target[i*6 +: 6];
            zc_wait[i] <= 1'h0;
          end
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (!rst_n) begin
      inverting_amp_on <= 1'h0;
      amp_output_route <= `ODV_ROUTE_RST;
    end else if (clk_en && hit[3]) begin
      // no check of the path pairing: software owns the path choice
      inverting_amp_on <= reg_wdata[`ODV_BIT_INV];
      amp_output_route <= reg_wdata[`ODV_BIT_ROUTE];
    end
  end

  // readback shows pending codes; commit bit always reads zero
  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `ODV_OFF_L1: reg_rdata <= {driver_on[0], driver_silence[0],
            zc_en[0], 5'h00, level_pend[5:0], 2'h0};
          `ODV_OFF_R1: reg_rdata <= {driver_on[1], driver_silence[1],
            zc_en[1], 5'h00, level_pend[11:6], 2'h0};
          `ODV_OFF_L2: reg_rdata <= {driver_on[2], driver_silence[2],
            zc_en[2], 5'h00, level_pend[17:12], 2'h0};
          `ODV_OFF_R2: reg_rdata <= {driver_on[3], driver_silence[3],
            zc_en[3], 2'h0, inverting_amp_on, amp_output_route, 1'h0,
            level_pend[23:18], 2'h0};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // odv_output_driver_volume_regs

/* File: verif/odv_monitor.sv */
// odv_monitor: port checks for the level bank
// assumes one clock domain, bound onto the bank
`timescale 1ns/1ns
module odv_monitor (
  input wire mclk, rst_n, clk_en, reg_wr,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [3:0] zero_seen, driver_on, driver_silence,
  input wire [23:0] level_applied,
  input wire inverting_amp_on, amp_output_route
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire w = reg_wr && clk_en;
  wire q = zero_seen == 4'h0;
  wire c = w && reg_wdata[8] && !reg_wdata[13];
  // quiet zero-cross inputs, else a deferred code may land legally
  hold_pend_a: assert property (q[*4] ##0 (w && !reg_wdata[8] &&
    !$past(w)) |=> $stable(level_applied)) else $error("early level");
  pair_one_a: assert property (c && reg_addr == 8'h69 |=>
    level_applied[11:6] == $past(reg_wdata[7:2])) else $error("pair one");
  pair_two_a: assert property (c && reg_addr == 8'h6B |=>
    level_applied[23:18] == $past(reg_wdata[7:2])) else $error("pair two");
  zero_wait_a: assert property (q[*3] ##1 (q && !w) ##1 (q && w &&
    reg_addr == 8'h68 && reg_wdata[13]) |=> $stable(level_applied[5:0]))
    else $error("zero cross");
  right_field_a: assert property (w && reg_addr == 8'h6B |=>
    {driver_on[3], driver_silence[3], inverting_amp_on, amp_output_route}
    == {$past(reg_wdata[15:14]), $past(reg_wdata[10:9])}) else $error("bits");
  reset_val_a: assert property (@(posedge mclk) disable iff (1'b0)
    !rst_n && clk_en |=> level_applied == 24'hE79E79 && driver_on == 4'h0
    && !inverting_amp_on && amp_output_route) else $error("reset");
endmodule // odv_monitor
bind odv_output_driver_volume_regs odv_monitor mon (.*);

/* File: verif/tb_top.sv */
// tb_top: row bench for the level bank
// assumes the bank and its monitor are compiled first
`timescale 1ns/1ns
module tb_top;
  reg mclk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  reg [7:0] reg_addr = 0;
  reg [15:0] reg_wdata = 0;
  reg [3:0] zero_seen = 0;
  wire [15:0] reg_rdata;
  wire [3:0] driver_on, driver_silence;
  wire [23:0] level_applied;
  wire inverting_amp_on, amp_output_route;
  integer fail_count = 0, n_checks = 0, cyc = 0, i;
  reg [63:0] rows [0:5];
  odv_output_driver_volume_regs dut (.*);
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 999) begin
    fail_count++;
    give_verdict;
  end
  task give_verdict;
    $display("checks %0d fails %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp(input [25:0] g, input [25:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t %h %h", $time, g, e);
    end
  endtask
  // strobes are rewritten every cycle, so no signal gets two drives
  task acc(input [7:0] a, input [15:0] d, input w, input r);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= r;
    #1;
  endtask
  initial begin
    rows[0] = 64'h68_0004_0004_E79E79;
    rows[1] = 64'h69_0108_0008_E79081;
    rows[2] = 64'h6A_00FC_00FC_E79081;
    rows[3] = 64'h6B_0100_0000_03F081;
    rows[4] = 64'h6B_C4FC_C4FC_03F081;
    rows[5] = 64'h70_01FC_0000_03F081;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    acc(8'h00, 16'h0000, 1'h0, 1'h0);
    cmp({inverting_amp_on, amp_output_route, level_applied}, 26'h1E79E79);
    $display("reset done");
    for (i = 0; i < 6; i++) begin
      acc(rows[i][63:56], rows[i][55:40], 1'h1, 1'h0);
      acc(rows[i][63:56], 16'h0000, 1'h0, 1'h1);
      acc(8'h00, 16'h0000, 1'h0, 1'h0);
      cmp(reg_rdata, rows[i][39:24]);
      cmp(level_applied, rows[i][23:0]);
      $display("row %0d done", i);
    end
    cmp({inverting_amp_on, amp_output_route}, 2'h2);
    cmp({driver_on, driver_silence}, 8'h88);
    acc(8'h6B, 16'h02FC, 1'h1, 1'h0);
    acc(8'h00, 16'h0000, 1'h0, 1'h0);
    cmp({inverting_amp_on, amp_output_route}, 2'h1);
    acc(8'h68, 16'h2114, 1'h1, 1'h0);
    repeat (4) acc(8'h00, 16'h0000, 1'h0, 1'h0);
    cmp(level_applied[5:0], 6'h01);
    @(posedge mclk) zero_seen <= 4'h1;
    repeat (8) acc(8'h00, 16'h0000, 1'h0, 1'h0);
    cmp(level_applied[5:0], 6'h05);
    $display("zero cross done");
    @(posedge mclk) clk_en <= 1'h0;
    acc(8'h6A, 16'h01C0, 1'h1, 1'h0);
    acc(8'h00, 16'h0000, 1'h0, 1'h0);
    cmp(level_applied[17:12], 6'h3F);
    @(posedge mclk) clk_en <= 1'h1;
    $display("freeze done");
    @(posedge mclk) rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    acc(8'h00, 16'h0000, 1'h0, 1'h0);
    cmp({inverting_amp_on, amp_output_route, level_applied}, 26'h1E79E79);
    $display("second reset done");
    give_verdict;
  end
endmodule // tb_top
